// File: hw/tmrch_chan.sv
// tmrch_chan: one timer channel: counter, general registers A/B, flags, enables
// assumes write strobes come from the APB decoder in tmrch_top and capture pins are synchronous
`timescale 1ns/1ps
module tmrch_chan
  import tmrch_pkg::*;
#(
  parameter int CW = 16
)(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // control
  input  wire logic          start,     // counting enable
  input  wire logic          standby,   // forces counter to zero
  input  wire logic          capPinA,   // capture pin A
  input  wire logic          capPinB,   // capture pin B
  // register writes
  input  wire logic          wrIer,
  input  wire logic          wrSr,
  input  wire logic          wrCnt,
  input  wire logic          wrGra,
  input  wire logic          wrGrb,
  input  wire logic          wrIoc,
  input  wire logic          rdSr,      // status read, arms the clear
  input  wire logic [31:0]   wdata,
  // state out
  output logic [7:0]         ierOut,
  output logic [7:0]         srOut,
  output logic [CW-1:0]      cntOut,
  output logic [CW-1:0]      graOut,
  output logic [CW-1:0]      grbOut,
  output logic [7:0]         iocOut,
  output logic [2:0]         irqNext    // ovf, b, a request next value
);
  // whole channel state
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [CW-1:0] gra;
    logic [CW-1:0] grb;
    logic [7:0]    ioc;
    logic          spare;    // ier bit 7
    logic [2:0]    en;       // ovf, b, a
    logic [2:0]    flag;     // ovf, b, a
    logic [2:0]    armed;    // flag seen as 1 by a read
    logic          pinA;
    logic          pinB;
  } tmrch_chan_t;

  tmrch_chan_t chan_q, chan_d;

  // edge detect by selected mode
  function automatic logic edgeHit(input logic cur, input logic prev, input logic [1:0] sel);
    if (sel[1])
      edgeHit = cur ^ prev;
    else if (sel[0])
      edgeHit = prev & ~cur;
    else
      edgeHit = cur & ~prev;
  endfunction : edgeHit

  logic capA, capB, cmpA, cmpB, ovf;

  // next state
  always_comb
  begin
    chan_d = chan_q;
    chan_d.pinA = capPinA;
    chan_d.pinB = capPinB;
    // capture strobes only in capture role
    capA = chan_q.ioc[IOC_ROLE_A] & edgeHit(capPinA, chan_q.pinA, chan_q.ioc[IOC_EDGE_A +: 2]);
    capB = chan_q.ioc[IOC_ROLE_B] & edgeHit(capPinB, chan_q.pinB, chan_q.ioc[IOC_EDGE_B +: 2]);
    cmpA = ~chan_q.ioc[IOC_ROLE_A] & (chan_q.cnt == chan_q.gra);
    cmpB = ~chan_q.ioc[IOC_ROLE_B] & (chan_q.cnt == chan_q.grb);
    ovf  = start & ~standby & ~wrCnt & (chan_q.cnt == CNT_MAX[CW-1:0]);
    // counter: standby beats software and counting
    if (standby)
      chan_d.cnt = CNT_RST[CW-1:0];
    else if (wrCnt)
      chan_d.cnt = wdata[CW-1:0];
    else if (start)
      chan_d.cnt = chan_q.cnt + 1'b1;
    // general registers, capture beats software write
    if (capA)
      chan_d.gra = chan_q.cnt;
    else if (wrGra)
      chan_d.gra = wdata[CW-1:0];
    if (capB)
      chan_d.grb = chan_q.cnt;
    else if (wrGrb)
      chan_d.grb = wdata[CW-1:0];
    if (wrIoc)
      chan_d.ioc = wdata[7:0];
    // enables; fixed bits are never stored
    if (wrIer)
    begin
      chan_d.spare = wdata[BIT_IER_SPARE];
      chan_d.en    = {wdata[BIT_OVF], wdata[BIT_B], wdata[BIT_A]};
    end
    // arm on read of a one
    if (rdSr)
      chan_d.armed = chan_q.armed | chan_q.flag;
    // clear only on 0 written to an armed flag; writing 1 keeps it
    if (wrSr)
    begin
      chan_d.flag  = chan_q.flag & ~(chan_q.armed & ~{wdata[BIT_OVF], wdata[BIT_B], wdata[BIT_A]});
      chan_d.armed = 3'b000;
    end
    // set wins over a simultaneous clear
    chan_d.flag = chan_d.flag | {ovf, cmpB | capB, cmpA | capA};
  end

  // state register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      chan_q <= '{cnt: CNT_RST[CW-1:0], gra: GR_RST[CW-1:0], grb: GR_RST[CW-1:0], default: '0};
    else
      chan_q <= chan_d;
  end

  // views for readback
  assign ierOut  = IER_FIXED1 | {chan_q.spare, 2'b00, chan_q.en[2], 2'b00, chan_q.en[1:0]};
  assign srOut   = SR_FIXED1 | {3'b000, chan_q.flag[2], 2'b00, chan_q.flag[1:0]};
  assign cntOut  = chan_q.cnt;
  assign graOut  = chan_q.gra;
  assign grbOut  = chan_q.grb;
  assign iocOut  = chan_q.ioc;
  assign irqNext = chan_d.flag & chan_d.en;

  // wrap sets overflow flag
  a_ovf_flag_set: assert property (@(posedge clock) disable iff (rst)
    (start && !standby && !wrCnt && chan_q.cnt == CNT_MAX[CW-1:0]) |=> (chan_q.flag[2] && chan_q.cnt == '0))
    else $error("overflow did not set flag");
  // standby holds zero
  a_standby_zero: assert property (@(posedge clock) disable iff (rst)
    standby |=> chan_q.cnt == '0)
    else $error("counter not zero in standby");
  // stopped counter holds
  a_count_hold: assert property (@(posedge clock) disable iff (rst)
    (!start && !standby && !wrCnt) |=> $stable(chan_q.cnt))
    else $error("counter moved while stopped");
  // write of one never clears
  a_write_one_keeps: assert property (@(posedge clock) disable iff (rst)
    (wrSr && wdata[BIT_A] && chan_q.flag[0]) |=> chan_q.flag[0])
    else $error("flag cleared by write of one");
  // a read of a one arms the flag; a zero in the next status write clears it unless an event sets it again
  sequence s_read_armed;
    rdSr && chan_q.flag[0] && !wrSr;
  endsequence
  sequence s_zero_armed;
    wrSr && chan_q.armed[0] && !wdata[BIT_A] && !cmpA && !capA;
  endsequence
  a_read_arms: assert property (@(posedge clock) disable iff (rst)
    s_read_armed |=> chan_q.armed[0])
    else $error("read of set flag did not arm");
  a_read_then_clear: assert property (@(posedge clock) disable iff (rst)
    s_zero_armed |=> !chan_q.flag[0])
    else $error("armed flag not cleared");
  // unarmed zero write keeps the flag
  a_unarmed_keep: assert property (@(posedge clock) disable iff (rst)
    (wrSr && !chan_q.armed[1] && chan_q.flag[1]) |=> chan_q.flag[1])
    else $error("unarmed flag cleared");
  // compare match in compare role
  a_match_b_set: assert property (@(posedge clock) disable iff (rst)
    (!chan_q.ioc[IOC_ROLE_B] && chan_q.cnt == chan_q.grb) |=> chan_q.flag[1])
    else $error("compare match b lost");
  // capture copies counter and sets flag
  a_capture_a: assert property (@(posedge clock) disable iff (rst)
    capA |=> (chan_q.gra == $past(chan_q.cnt) && chan_q.flag[0]))
    else $error("capture a wrong");
  // fixed bits
  a_fixed_bits: assert property (@(posedge clock) disable iff (rst)
    (ierOut[6] && ierOut[3:2] == 2'b00 && srOut[7:6] == 2'b11 && srOut[5] == 1'b0))
    else $error("fixed bits wrong");
endmodule : tmrch_chan

// File: hw/tmrch_pkg.sv
// tmrch_pkg: register map, field positions, reset values for the two-channel timer flag block
// assumes a 32-bit APB slave with one aligned word per register
package tmrch_pkg;
  // byte offsets, channel stride
  localparam logic [7:0] OFS_IER      = 8'h00; // interrupt_enable_reg
  localparam logic [7:0] OFS_SR       = 8'h04; // status_flag_reg
  localparam logic [7:0] OFS_CNT      = 8'h08; // channel_counter
  localparam logic [7:0] OFS_GRA      = 8'h0C; // general_reg_a
  localparam logic [7:0] OFS_GRB      = 8'h10; // general_reg_b
  localparam logic [7:0] OFS_IOC      = 8'h14; // io_control_reg (role bits, capture edges)
  localparam logic [7:0] CH_STRIDE    = 8'h20; // channel 2 block offset
  localparam logic [7:0] OFS_CTRL     = 8'h40; // start bits, standby
  // field positions
  localparam int BIT_OVF       = 4;
  localparam int BIT_B         = 1;
  localparam int BIT_A         = 0;
  localparam int BIT_IER_SPARE = 7;
  localparam int IOC_ROLE_A    = 3;  // io_control_role_bit for A
  localparam int IOC_ROLE_B    = 7;  // role bit for B
  localparam int IOC_EDGE_A    = 0;  // 2-bit edge select: 00 rise, 01 fall, 1x both
  localparam int IOC_EDGE_B    = 4;
  localparam int CTRL_START1   = 1;  // channel1_start_bit
  localparam int CTRL_START2   = 2;  // channel2_start_bit
  localparam int CTRL_STANDBY  = 0;
  // fixed read values
  localparam logic [7:0] IER_FIXED1  = 8'h40;
  localparam logic [7:0] SR_FIXED1   = 8'hC0;
  // reset values
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] GR_RST     = 16'hFFFF;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
endpackage : tmrch_pkg

// File: hw/tmrch_top.sv
// tmrch_top: APB slave for a two-channel 16-bit timer flag block
// assumes one synchronous clock; capture pins are synchronous to it
//
// How it works
// - overflow request needs enable bit four
// - b request needs enable bit one
// - a request needs enable bit zero
// - enable bit7 stores, bit6 one, 3:2 zero
// - status bits 7,6 one; 5,3,2 zero
// - counter wrap sets overflow flag
// - zero after read-as-one clears flag
// - writing one leaves flag unchanged
// - b compare match sets b flag
// - b capture sets b flag
// - a compare match sets a flag
// - a capture sets a flag
// - each channel has its own counter
// - reset and standby zero the counter
// - two general registers per channel
// - reset loads general registers all ones
// - separate enable and status per channel
// - role bit picks compare or capture
// - counter advances only while started
`timescale 1ns/1ps
module tmrch_top
  import tmrch_pkg::*;
#(
  parameter int CW = 16
)(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // capture pins
  input  wire logic [1:0]    capPinA,
  input  wire logic [1:0]    capPinB,
  // interrupt requests per channel
  output logic [1:0]         overflowIrqRequest,
  output logic [1:0]         matchBIrqRequest,
  output logic [1:0]         matchAIrqRequest
);
  // top state
  typedef struct packed {
    logic [2:0]  ctrl;     // start2, start1, standby
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [1:0]  irqOvf;
    logic [1:0]  irqB;
    logic [1:0]  irqA;
  } tmrch_top_t;

  tmrch_top_t top_q, top_d;

  // per-channel views
  logic [7:0]    ier    [2];
  logic [7:0]    sr     [2];
  logic [CW-1:0] cnt    [2];
  logic [CW-1:0] gra    [2];
  logic [CW-1:0] grb    [2];
  logic [7:0]    ioc    [2];
  logic [2:0]    irqN   [2];
  logic [5:0]    wrSel  [2];   // ier, sr, cnt, gra, grb, ioc
  logic [1:0]    rdSr;

  // access phase: the answer is built in the first access cycle, writes commit at the edge that
  // samples pready high, so no write lands before the master has seen the answer
  logic acc, hit, wr, rd, full;
  assign acc  = psel & penable & ~top_q.ready;
  assign hit  = psel & penable & top_q.ready;
  assign wr   = hit & pwrite;
  assign rd   = acc & ~pwrite;
  assign full = &pstrb;

  // channel index from address
  function automatic int chIdx(input logic [7:0] a);
    chIdx = (a >= CH_STRIDE) ? 1 : 0;
  endfunction : chIdx

  // address decode and bus answer
  always_comb
  begin
    top_d       = top_q;
    top_d.ready = acc;
    top_d.err   = 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      wrSel[c] = 6'b000000;
      rdSr[c]  = 1'b0;
    end
    if (psel && penable)
    begin
      if (paddr == OFS_CTRL)
      begin
        if (acc)
          top_d.rdata = {29'h0, top_q.ctrl};
        if (wr)
          top_d.ctrl = pwdata[2:0];
      end
      else if (paddr < OFS_CTRL && (paddr & (CH_STRIDE - 8'h01)) <= OFS_IOC && paddr[1:0] == 2'b00)
      begin
        if (acc)
        begin
          case (paddr & (CH_STRIDE - 8'h01))
            OFS_IER: top_d.rdata = {24'h0, ier[chIdx(paddr)]};
            OFS_SR:  top_d.rdata = {24'h0, sr[chIdx(paddr)]};
            OFS_CNT: top_d.rdata = {16'h0, cnt[chIdx(paddr)]};
            OFS_GRA: top_d.rdata = {16'h0, gra[chIdx(paddr)]};
            OFS_GRB: top_d.rdata = {16'h0, grb[chIdx(paddr)]};
            default: top_d.rdata = {24'h0, ioc[chIdx(paddr)]};
          endcase
        end
        if (wr && full)
          wrSel[chIdx(paddr)] = 6'b000001 << 3'((paddr & (CH_STRIDE - 8'h01)) >> 2);
        // partial-width writes are refused with an error
        if (acc && pwrite && !full)
          top_d.err = 1'b1;
        if (rd && (paddr & (CH_STRIDE - 8'h01)) == OFS_SR)
          rdSr[chIdx(paddr)] = 1'b1;
      end
      else if (acc)
      begin
        // unmapped: zero data and error
        top_d.rdata = 32'h0000_0000;
        top_d.err   = 1'b1;
      end
    end
    // registered requests
    top_d.irqOvf = {irqN[1][2], irqN[0][2]};
    top_d.irqB   = {irqN[1][1], irqN[0][1]};
    top_d.irqA   = {irqN[1][0], irqN[0][0]};
  end

  // state register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      top_q <= '0;
    else
      top_q <= top_d;
  end

  // two channels, each its own counter and flags
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    tmrch_chan #(.CW(CW)) u_chan (
      .clock   (clock),
      .rst     (rst),
      .start   (top_q.ctrl[c == 0 ? CTRL_START1 : CTRL_START2]),
      .standby (top_q.ctrl[CTRL_STANDBY]),
      .capPinA (capPinA[c]),
      .capPinB (capPinB[c]),
      .wrIer   (wrSel[c][0]),
      .wrSr    (wrSel[c][1]),
      .wrCnt   (wrSel[c][2]),
      .wrGra   (wrSel[c][3]),
      .wrGrb   (wrSel[c][4]),
      .wrIoc   (wrSel[c][5]),
      .rdSr    (rdSr[c]),
      .wdata   (pwdata),
      .ierOut  (ier[c]),
      .srOut   (sr[c]),
      .cntOut  (cnt[c]),
      .graOut  (gra[c]),
      .grbOut  (grb[c]),
      .iocOut  (ioc[c]),
      .irqNext (irqN[c])
    );
  end

  // outputs straight from flip-flops
  assign prdata             = top_q.rdata;
  assign pready             = top_q.ready;
  assign pslverr            = top_q.err;
  assign overflowIrqRequest = top_q.irqOvf;
  assign matchBIrqRequest   = top_q.irqB;
  assign matchAIrqRequest   = top_q.irqA;

  // answer comes one cycle into the access phase
  a_apb_answer: assert property (@(posedge clock) disable iff (rst)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");
  // request register is loaded with the same edge as flag and enable, so it always equals their and
  a_irq_level: assert property (@(posedge clock) disable iff (rst)
    overflowIrqRequest == {ier[1][BIT_OVF] & sr[1][BIT_OVF], ier[0][BIT_OVF] & sr[0][BIT_OVF]})
    else $error("overflow request wrong");
  // match requests likewise
  a_irq_match: assert property (@(posedge clock) disable iff (rst)
    (matchBIrqRequest == {ier[1][BIT_B] & sr[1][BIT_B], ier[0][BIT_B] & sr[0][BIT_B]}) &&
    (matchAIrqRequest == {ier[1][BIT_A] & sr[1][BIT_A], ier[0][BIT_A] & sr[0][BIT_A]}))
    else $error("match request wrong");
endmodule : tmrch_top

// File: testbench/tb_timer_channel_flags_counter.sv
// tb_timer_channel_flags_counter: self-checking bench for the two-channel timer flag block
// assumes tmrch_top as the device, reached over apb at 200 MHz, capture pins synchronous
`timescale 1ns/1ps
module tb_timer_channel_flags_counter;
  import tmrch_pkg::*;
  // apb master side
  logic        clock   = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // capture pins and requests
  logic [1:0]  capPinA = 2'h0;
  logic [1:0]  capPinB = 2'h0;
  logic [1:0]  ovfIrq;
  logic [1:0]  irqB;
  logic [1:0]  irqA;
  // bench state
  int          fails   = 0;
  int          checked = 0;
  int          seed    = 57;
  logic [31:0] rdv;        // data of the last transfer
  logic        rerr;       // error flag of the last transfer
  logic [7:0]  b;          // channel base address
  logic [7:0]  o;          // general register offset
  logic [7:0]  m;          // flag mask under test
  logic [15:0] v;          // model copy of the counter

  // free-running clock
  always #2.5 clock = ~clock;

  tmrch_top #(.CW(16)) u_dut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capPinA(capPinA), .capPinB(capPinB),
    .overflowIrqRequest(ovfIrq), .matchBIrqRequest(irqB), .matchAIrqRequest(irqA)
  );

  // single comparison point
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; waits for pready with a bound, no assumed latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdv     = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      fails++;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, 4'hF);
    check(rdv, exp);
  endtask : rd

  // requests are registered, so let two edges land first
  task settle;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask : settle

  // request order is overflow, b, a
  task irqs(input int c, input logic [2:0] e);
    check({29'h0, ovfIrq[c], irqB[c], irqA[c]}, {29'h0, e});
  endtask : irqs

  task test_done;
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // watchdog: the run needs a few thousand cycles at most
  initial
  begin
    #100000;
    fails++;
    test_done();
  end

  // main sequence, once per channel
  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      b = c ? CH_STRIDE : 8'h00;
      rd(b + OFS_IER, {24'h0, IER_FIXED1});
      rd(b + OFS_SR, {24'h0, SR_FIXED1});
      rd(b + OFS_CNT, {16'h0, CNT_RST});
      rd(b + OFS_GRA, {16'h0, GR_RST});
      rd(b + OFS_GRB, {16'h0, GR_RST});
      wr(b + OFS_IER, 32'hDF);
      rd(b + OFS_IER, 32'hD3);
      wr(b + OFS_IER, 32'h00);
      wr(b + OFS_SR, 32'hFF);
      rd(b + OFS_SR, 32'hC0);
      // stopped counter holds a random value; top bit clear keeps it off the all-ones registers
      v = 16'($random(seed)) & 16'h7FFF;
      wr(b + OFS_CNT, {16'hA5A5, v});
      repeat (4) @(posedge clock);
      rd(b + OFS_CNT, {16'h0, v});
      // compare match on a, then b
      for (int k = 0; k < 2; k++)
      begin
        o = k ? OFS_GRB : OFS_GRA;
        m = k ? 8'h02 : 8'h01;
        wr(b + o, {16'h0, v});
        wr(b + OFS_IER, {24'h0, m});
        settle();
        irqs(c, {1'b0, m[1:0]});
        wr(b + o, {16'h0, GR_RST});
        wr(b + OFS_SR, 32'h00);
        rd(b + OFS_SR, {24'h0, SR_FIXED1 | m});
        wr(b + OFS_SR, 32'hFF);
        rd(b + OFS_SR, {24'h0, SR_FIXED1 | m});
        wr(b + OFS_SR, {24'h0, ~m});
        rd(b + OFS_SR, {24'h0, SR_FIXED1});
        settle();
        irqs(c, 3'b000);
      end
      // run through the wrap; all-ones registers match on the way
      wr(b + OFS_CNT, 32'hFFF0);
      wr(OFS_CTRL, 32'h1 << (c ? CTRL_START2 : CTRL_START1));
      repeat (20) @(posedge clock);
      wr(OFS_CTRL, 32'h0);
      rd(b + OFS_SR, 32'hD3);
      apb(1'b0, b + OFS_CNT, 32'h0, 4'hF);
      v = rdv[15:0];
      check({31'h0, v < 16'h0040}, 32'h1);
      repeat (5) @(posedge clock);
      rd(b + OFS_CNT, {16'h0, v});
      rd((c ? 8'h00 : CH_STRIDE) + OFS_SR, 32'hC0);
      wr(b + OFS_IER, 32'h13);
      settle();
      irqs(c, 3'b111);
      wr(b + OFS_IER, 32'h00);
      settle();
      irqs(c, 3'b000);
      wr(b + OFS_SR, 32'h00);
      rd(b + OFS_SR, 32'hC0);
      // standby zeroes the counter
      wr(b + OFS_CNT, 32'h1357);
      wr(OFS_CTRL, 32'h1);
      rd(b + OFS_CNT, 32'h0);
      wr(OFS_CTRL, 32'h0);
      // capture on rising edges of both pins
      v = 16'($random(seed)) & 16'h7FFF;
      wr(b + OFS_CNT, {16'h0, v});
      wr(b + OFS_IOC, 32'h88);
      @(posedge clock);
      capPinA[c] <= 1'b1;
      capPinB[c] <= 1'b1;
      repeat (3) @(posedge clock);
      capPinA[c] <= 1'b0;
      capPinB[c] <= 1'b0;
      rd(b + OFS_GRA, {16'h0, v});
      rd(b + OFS_GRB, {16'h0, v});
      rd(b + OFS_SR, 32'hC3);
      wr(b + OFS_SR, 32'h00);
      // counter equals the captured value, yet capture role gives no match flag
      rd(b + OFS_SR, 32'hC0);
    end
    // refusals: unmapped address and a narrow write
    apb(1'b0, 8'h3C, 32'h0, 4'hF);
    check({31'h0, rerr}, 32'h1);
    check(rdv, 32'h0);
    apb(1'b1, b + OFS_GRA, 32'h1234, 4'h3);
    check({31'h0, rerr}, 32'h1);
    rd(b + OFS_GRA, {16'h0, v});
    // a narrow counter write is refused and leaves the stopped counter alone
    apb(1'b1, b + OFS_CNT, 32'h5555, 4'h3);
    check({31'h0, rerr}, 32'h1);
    rd(b + OFS_CNT, {16'h0, v});
    test_done();
  end
endmodule : tb_timer_channel_flags_counter
